// File: core/isx_defines.svh
// constants for the instruction subset executor: opcodes, flags, timing
`ifndef ISX_DEFINES_SVH
`define ISX_DEFINES_SVH
`define OP_ADD_LIT      8'hB1
`define OP_RET_LIT      8'hB6
`define OP_XOR_LIT      8'hB4
`define OP_DEC_PFX      7'h03
`define OP_DECSZ_PFX    7'h0B
`define OP_DECSNZ_PFX   7'h13
`define OP_INC_PFX      7'h0A
`define OP_INCSZ_PFX    7'h0F
`define OP_XOR_REG_PFX  7'h06
`define OP_ADD_REG_PFX  7'h07
`define OP_JUMP_PFX     3'h6
`define OP_IRQ_RET      16'h0005
`define FLAG_OVFL_BIT   3
`define FLAG_Z_BIT      2
`define FLAG_DIGC_BIT   1
`define FLAG_C_BIT      0
`define GIRQ_DIS_BIT    4
`define STATUS_RESET    8'h10
`define ALU_RESET       4'h0
`define PHASES          4
`endif

// File: core/isx_pkg.sv
// types shared by the instruction subset executor
`default_nettype none
package isx_pkg;
  typedef enum logic [3:0] {
    PH_DECODE  = 4'b0001,
    PH_READ    = 4'b0010,
    PH_EXECUTE = 4'b0100,
    PH_WRITE   = 4'b1000
  } phase_t;
  typedef enum logic [3:0] {
    ALU_ADD, ALU_INC, ALU_DEC, ALU_XOR, ALU_PASS
  } alu_op_t;
endpackage : isx_pkg
`default_nettype wire

// File: core/isx_alu_if.sv
// carrier between the sequencer and its arithmetic unit
`timescale 1ns/1ns
`default_nettype none
interface isx_alu_if;
  import isx_pkg::*;
  alu_op_t    op;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] res;
  logic [3:0] flags;
  modport seq (output op, output a, output b, input res, input flags);
  modport alu (input op, input a, input b, output res, output flags);
endinterface : isx_alu_if
`default_nettype wire

// File: core/isx_alu.sv
// arithmetic unit: result plus overflow, zero, digit carry and carry
`timescale 1ns/1ns
`default_nettype none
`include "isx_defines.svh"
module isx_alu
  import isx_pkg::*;
(
  isx_alu_if.alu bus
);
  logic [8:0] sum;
  logic [4:0] low;
  logic [7:0] bb;
  always_comb begin
    bb = bus.b;
    unique case (bus.op)
      ALU_INC: bb = 8'h01;
      ALU_DEC: bb = 8'hFF;
      default: bb = bus.b;
    endcase
    sum = {1'b0, bus.a} + {1'b0, bb};
    low = {1'b0, bus.a[3:0]} + {1'b0, bb[3:0]};
    bus.res = sum[7:0];
    if (bus.op == ALU_XOR) begin
      bus.res = bus.a ^ bus.b;
    end else if (bus.op == ALU_PASS) begin
      bus.res = bus.b;
    end
    bus.flags = 4'h0;
    bus.flags[`FLAG_C_BIT]  = sum[8];
    bus.flags[`FLAG_DIGC_BIT] = low[4];
    bus.flags[`FLAG_Z_BIT]  = (bus.res == 8'h00);
    bus.flags[`FLAG_OVFL_BIT] = (bus.a[7] == bb[7]) && (sum[7] != bus.a[7]);
  end
endmodule : isx_alu
`default_nettype wire

// File: core/isx_exec.sv
// sequencer for the instruction subset with four phases per cycle
`timescale 1ns/1ns
`default_nettype none
`include "isx_defines.svh"
module isx_exec
  import isx_pkg::*;
#(
  parameter int PC_W = 16
)(
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  input  wire logic [15:0]     instr,
  input  wire logic [PC_W-1:0] stack_top,
  input  wire logic [7:0]      file_rdata,
  input  wire logic            irq_disable_set,
  output logic [7:0]           file_addr,
  output logic [7:0]           file_wdata,
  output logic                 file_we,
  output logic [7:0]           working_accumulator,
  output logic [3:0]           alu_flags,
  output logic [7:0]           cpu_status_reg,
  output logic [7:0]           pc_high_latch,
  output logic [PC_W-1:0]      pc,
  output logic                 stack_pop,
  output logic                 fetch_flush,
  output logic [3:0]           phase
);
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  phase_t     ph_q;
  logic [15:0] ir_q;
  logic       flush_q;
  logic [7:0] opnd_q;
  logic [7:0] res_q;
  logic [3:0] fl_q;
  logic       skip_q;
  logic [6:0] pfx;
  logic is_addl, is_retl, is_xorl, is_dec, is_decsz, is_decsnz, is_inc;
  logic is_incsz, is_xorf, is_addf, is_jump, is_iret, reg_op, dest_f;
  isx_alu_if alu_bus ();
  isx_alu u_alu (.bus(alu_bus));

  assign pfx       = ir_q[15:9];
  assign is_addl   = ir_q[15:8] == `OP_ADD_LIT;
  assign is_retl   = ir_q[15:8] == `OP_RET_LIT;
  assign is_xorl   = ir_q[15:8] == `OP_XOR_LIT;
  assign is_dec    = pfx == `OP_DEC_PFX;
  assign is_decsz  = pfx == `OP_DECSZ_PFX;
  assign is_decsnz = pfx == `OP_DECSNZ_PFX;
  assign is_inc    = pfx == `OP_INC_PFX;
  assign is_incsz  = pfx == `OP_INCSZ_PFX;
  assign is_xorf   = pfx == `OP_XOR_REG_PFX;
  assign is_addf   = pfx == `OP_ADD_REG_PFX;
  assign is_jump   = ir_q[15:13] == `OP_JUMP_PFX;
  assign is_iret   = ir_q == `OP_IRQ_RET;
  assign reg_op    = is_dec | is_decsz | is_decsnz | is_inc | is_incsz
                   | is_xorf | is_addf;
  assign dest_f    = ir_q[8];

  // ------------------------------------------------------------
  // alu hookup
  // ------------------------------------------------------------
  always_comb begin
    alu_bus.a  = working_accumulator;
    alu_bus.b  = opnd_q;
    alu_bus.op = ALU_PASS;
    if (is_addl | is_addf) begin
      alu_bus.op = ALU_ADD;
    end else if (is_xorl | is_xorf) begin
      alu_bus.op = ALU_XOR;
    end else if (is_inc | is_incsz) begin
      alu_bus.op = ALU_INC;
      alu_bus.a  = opnd_q;
    end else if (is_dec | is_decsz | is_decsnz) begin
      alu_bus.op = ALU_DEC;
      alu_bus.a  = opnd_q;
    end
  end

  // ------------------------------------------------------------
  // phase sequencer
  // ------------------------------------------------------------
  // four phases
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ph_q <= PH_DECODE;
    end else begin
      unique case (ph_q)
        PH_DECODE:  ph_q <= PH_READ;
        PH_READ:    ph_q <= PH_EXECUTE;
        PH_EXECUTE: ph_q <= PH_WRITE;
        PH_WRITE:   ph_q <= PH_DECODE;
      endcase
    end
  end

  // instruction latch; a flushed word becomes a forced no-op
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ir_q    <= 16'h0000;
      flush_q <= 1'b0;
    end else if (ph_q == PH_WRITE) begin
      ir_q    <= instr;
      flush_q <= 1'b0;
      if (!flush_q && (is_jump | is_iret | is_retl | skip_q)) begin
        ir_q    <= 16'h0000;
        flush_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // operand read and execute
  // ------------------------------------------------------------
  // operand read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      opnd_q <= 8'h00;
    end else if (ph_q == PH_READ) begin
      opnd_q <= reg_op ? file_rdata : ir_q[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      res_q  <= 8'h00;
      fl_q   <= `ALU_RESET;
      skip_q <= 1'b0;
    end else if (ph_q == PH_EXECUTE && !flush_q) begin
      res_q  <= alu_bus.res;
      fl_q   <= alu_bus.flags;
      skip_q <= ((is_incsz | is_decsz) && alu_bus.res == 8'h00)
              | (is_decsnz && alu_bus.res != 8'h00);
    end else if (ph_q == PH_DECODE) begin
      skip_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // write-back
  // ------------------------------------------------------------
  logic wb;
  assign wb = (ph_q == PH_WRITE) && !flush_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      working_accumulator <= 8'h00;
      file_we             <= 1'b0;
      file_wdata          <= 8'h00;
      file_addr           <= 8'h00;
    end else begin
      file_we   <= 1'b0;
      file_addr <= ir_q[7:0];
      if (wb) begin
        if (is_addl | is_xorl | is_retl) begin
          working_accumulator <= res_q;
        end else if (reg_op && !dest_f) begin
          working_accumulator <= res_q;
        end else if (reg_op) begin
          file_we    <= 1'b1;
          file_wdata <= res_q;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      alu_flags <= `ALU_RESET;
    end else if (wb) begin
      if (is_addl | is_addf | is_inc | is_dec) begin
        alu_flags <= fl_q;
      end else if (is_xorl | is_xorf) begin
        alu_flags[`FLAG_Z_BIT] <= fl_q[`FLAG_Z_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // program counter, latch, status
  // ------------------------------------------------------------
  // latch takes the high byte after the target is merged in
  logic [PC_W-1:0] jump_pc;
  assign jump_pc = {pc[PC_W-1:13], ir_q[12:0]};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pc            <= '0;
      pc_high_latch <= 8'h00;
      stack_pop     <= 1'b0;
    end else begin
      stack_pop <= 1'b0;
      if (ph_q == PH_DECODE) begin
        pc <= pc + 1'b1;
      end
      if (wb && is_jump) begin
        pc            <= jump_pc;
        pc_high_latch <= jump_pc[PC_W-1:PC_W-8];
      end else if (wb && (is_iret | is_retl)) begin
        pc        <= stack_top;
        stack_pop <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cpu_status_reg <= `STATUS_RESET;
    end else if (wb && is_iret) begin
      cpu_status_reg[`GIRQ_DIS_BIT] <= 1'b0;
    end else if (irq_disable_set) begin
      cpu_status_reg[`GIRQ_DIS_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fetch_flush <= 1'b0;
      phase       <= 4'b0001;
    end else begin
      fetch_flush <= (ph_q == PH_WRITE) && !flush_q
                   && (is_jump | is_iret | is_retl | skip_q);
      phase       <= ph_q;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_jump_flush: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ph_q == PH_WRITE && !flush_q && is_jump) |=> flush_q && ir_q == 16'h0)
    else $error("jump did not force a no-op cycle");
  a_iret_gie: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wb && is_iret) |=> !cpu_status_reg[`GIRQ_DIS_BIT])
    else $error("interrupt return left interrupts disabled");
  a_iret_pc: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wb && is_iret) |=> pc == $past(stack_top) && $stable(pc_high_latch))
    else $error("interrupt return pc wrong");
  a_skip_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wb && (is_incsz | is_decsz)) |=> $stable(alu_flags))
    else $error("skip instruction changed flags");
  a_skipz_flush: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wb && is_incsz && res_q == 8'h00) |=> flush_q)
    else $error("zero skip did not flush");
  a_snz_flush: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wb && is_decsnz && res_q != 8'h00) |=> flush_q)
    else $error("nonzero skip did not flush");
  a_dest_reg: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wb && reg_op && dest_f) |=> file_we && $stable(working_accumulator))
    else $error("register destination not written");
  a_xor_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wb && is_xorf) |=> alu_flags[`FLAG_C_BIT] == $past(alu_flags[0]))
    else $error("xor changed carry");
  a_jump_pc: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wb && is_jump) |=> pc[12:0] == $past(ir_q[12:0]))
    else $error("jump target wrong");
  a_jump_latch: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wb && is_jump) |=> pc_high_latch[4:0] == $past(ir_q[12:8]))
    else $error("jump high latch wrong");
  a_phase_seq: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ph_q == PH_DECODE) |=> ph_q == PH_READ ##1 ph_q == PH_EXECUTE
      ##1 ph_q == PH_WRITE)
    else $error("phase order broken");
  c_jump: cover property (@(posedge clk_sys) disable iff (!rst_n)
    wb && is_jump);
  c_skip: cover property (@(posedge clk_sys) disable iff (!rst_n)
    wb && skip_q);
  c_retl: cover property (@(posedge clk_sys) disable iff (!rst_n)
    wb && is_retl);
endmodule : isx_exec
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the instruction subset executor
`timescale 1ns/1ns
`default_nettype none
`include "isx_defines.svh"
module tb_top;
  // ----------------------------------------------------------
  // stimulus, model state and scoreboard
  // ----------------------------------------------------------
  typedef struct {
    logic [7:0]  acc;
    logic [3:0]  flg;
    logic [7:0]  st;
    logic [7:0]  plh;
    logic [7:0]  wd;
    logic [7:0]  adr;
    logic        we;
    logic        pop;
    logic        fl;
    logic        cpc;
    logic [15:0] pc;
  } note_t;
  logic        clk_sys = 1'h0;
  logic        rst_n   = 1'h0;
  logic [15:0] instr;
  logic [15:0] stack_top;
  logic [15:0] pc;
  logic [7:0]  file_rdata;
  logic        irq_disable_set;
  logic [7:0]  file_addr;
  logic [7:0]  file_wdata;
  logic        file_we;
  logic [7:0]  working_accumulator;
  logic [3:0]  alu_flags;
  logic [7:0]  cpu_status_reg;
  logic [7:0]  pc_high_latch;
  logic        stack_pop;
  logic        fetch_flush;
  logic [3:0]  phase;
  logic [7:0]  m_acc;
  logic [7:0]  m_st;
  logic [7:0]  m_plh;
  logic [3:0]  m_flg;
  logic        m_skip;
  logic        seen;
  logic [6:0]  pf [7];
  note_t       q [$];
  int          num_errors;
  int          num_checks;
  int          cyc;
  int          i;
  int          sel;

  always #5 clk_sys = ~clk_sys;

  isx_exec #(.PC_W(16)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .instr(instr),
    .stack_top(stack_top), .file_rdata(file_rdata),
    .irq_disable_set(irq_disable_set), .file_addr(file_addr),
    .file_wdata(file_wdata), .file_we(file_we),
    .working_accumulator(working_accumulator), .alu_flags(alu_flags),
    .cpu_status_reg(cpu_status_reg), .pc_high_latch(pc_high_latch),
    .pc(pc), .stack_pop(stack_pop), .fetch_flush(fetch_flush),
    .phase(phase));

  // sum and its four flags; decrement is an add of 8'hFF
  function automatic logic [11:0] add8(input logic [7:0] a,
                                       input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'h0, a} + {1'h0, b};
    h = {1'h0, a[3:0]} + {1'h0, b[3:0]};
    return {s[7:0], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00,
            h[4], s[8]};
  endfunction : add8

  task automatic chk(input logic ok, input string what);
    num_checks++;
    if (!ok) begin
      num_errors++;
      $display("[ERR] %0t mismatch on %s", $time, what);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task automatic wait_ph(input logic [3:0] p);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (phase !== p && n < 12);
    if (phase !== p) begin
      chk(1'h0, "phase wait");
      close_out();
    end
  endtask : wait_ph

  // stack_top and irq driven half a cycle after the take edge, held through write-back edge
  task automatic run_op(input logic [15:0] w, input logic [7:0] rd,
                        input logic irq);
    note_t       n;
    logic [11:0] a;
    logic        hit;
    logic        clr;
    logic [15:0] ret_addr;
    ret_addr = 16'($urandom);
    wait_ph(4'h4);
    instr      = w;
    file_rdata = rd;
    wait_ph(4'h8);
    irq_disable_set = irq;
    stack_top       = ret_addr;
    n = '{8'h00, 4'h0, 8'h00, 8'h00, 8'h00, w[7:0], 1'h0, 1'h0, 1'h0,
          1'h0, 16'h0000};
    hit = 1'h0;
    clr = 1'h0;
    a   = 12'h000;
    if (m_skip) begin
      m_skip = 1'h0;
    end else if (w[15:8] == `OP_ADD_LIT) begin
      {m_acc, m_flg} = add8(m_acc, w[7:0]);
    end else if (w[15:8] == `OP_XOR_LIT) begin
      m_acc = m_acc ^ w[7:0];
      m_flg[`FLAG_Z_BIT] = (m_acc == 8'h00);
    end else if (w == `OP_IRQ_RET || w[15:8] == `OP_RET_LIT) begin
      clr = (w == `OP_IRQ_RET);
      if (!clr) begin
        m_acc = w[7:0];
      end
      {n.pop, n.fl, n.cpc, m_skip} = 4'hF;
      n.pc = ret_addr;
    end else if (w[15:13] == `OP_JUMP_PFX) begin
      m_plh = {3'h0, w[12:8]};
      {n.fl, n.cpc, m_skip} = 3'h7;
      n.pc = {3'h0, w[12:0]};
    end else begin
      hit = 1'h1;
      case (w[15:9])
        `OP_ADD_REG_PFX: a = add8(m_acc, rd);
        `OP_INC_PFX, `OP_INCSZ_PFX: a = add8(rd, 8'h01);
        `OP_DEC_PFX, `OP_DECSZ_PFX, `OP_DECSNZ_PFX: a = add8(rd, 8'hFF);
        `OP_XOR_REG_PFX: a = {m_acc ^ rd, m_flg[3],
                              (m_acc ^ rd) == 8'h00, m_flg[1:0]};
        default: hit = 1'h0;
      endcase
    end
    if (hit) begin
      if (w[15:9] == `OP_INCSZ_PFX || w[15:9] == `OP_DECSZ_PFX) begin
        m_skip = (a[11:4] == 8'h00);
      end else if (w[15:9] == `OP_DECSNZ_PFX) begin
        m_skip = (a[11:4] != 8'h00);
      end else begin
        m_flg = a[3:0];
      end
      n.fl = m_skip;
      if (w[8]) begin
        {n.we, n.wd} = {1'h1, a[11:4]};
      end else begin
        m_acc = a[11:4];
      end
    end
    // clearing wins over a held set at the same edge
    m_st[`GIRQ_DIS_BIT] = irq ? !clr : m_st[`GIRQ_DIS_BIT] && !clr;
    {n.acc, n.flg, n.st, n.plh} = {m_acc, m_flg, m_st, m_plh};
    wait_ph(4'h1);
    q.push_back(n);
  endtask : run_op

  task automatic lit(input logic [7:0] op, input logic [7:0] k);
    run_op({op, k}, 8'($urandom), 1'h0);
  endtask : lit

  task automatic rop(input logic [6:0] p, input logic d,
                     input logic [7:0] rd);
    run_op({p, d, 8'($urandom)}, rd, 1'h0);
  endtask : rop

  // ----------------------------------------------------------
  // result watcher, one note per write-back
  // ----------------------------------------------------------
  always @(negedge clk_sys) begin : mon
    note_t n;
    if (rst_n) begin
      cyc++;
      if (phase === 4'h8) begin
        if (seen) chk(cyc == 4, "cycle length");
        seen = 1'h1;
        cyc  = 0;
        if (q.size() > 0) begin
          n = q.pop_front();
          chk(working_accumulator === n.acc, "acc");
          chk(alu_flags === n.flg, "flags");
          chk(cpu_status_reg === n.st, "status");
          chk(pc_high_latch === n.plh, "high latch");
          chk(file_we === n.we, "write strobe");
          chk(stack_pop === n.pop, "stack pop");
          chk(fetch_flush === n.fl, "flush");
          if (n.we) chk({file_addr, file_wdata} === {n.adr, n.wd}, "wr");
          if (n.cpc) chk(pc === n.pc, "pc");
        end
      end
    end
  end

  initial begin
    {instr, stack_top, file_rdata, irq_disable_set} = 41'h0;
    {m_acc, m_plh, m_flg, m_skip, seen} = 22'h00_0000;
    m_st = `STATUS_RESET;
    {num_errors, num_checks, cyc} = 96'h0;
    pf = '{`OP_DEC_PFX, `OP_DECSZ_PFX, `OP_DECSNZ_PFX, `OP_INC_PFX,
           `OP_INCSZ_PFX, `OP_XOR_REG_PFX, `OP_ADD_REG_PFX};
    void'($urandom(32'h0000_99a7));
    repeat (16) @(negedge clk_sys);
    chk({working_accumulator, alu_flags, cpu_status_reg, phase, pc} ===
        {8'h00, 4'h0, 8'h10, 4'h1, 16'h0000}, "reset");
    rst_n = 1'h1;
    lit(`OP_ADD_LIT, 8'h7F);
    lit(`OP_ADD_LIT, 8'h01);
    lit(`OP_ADD_LIT, 8'h80);
    lit(`OP_XOR_LIT, 8'($urandom));
    for (i = 0; i < 2; i++) begin
      rop(`OP_ADD_REG_PFX, i[0], 8'($urandom));
      rop(`OP_XOR_REG_PFX, i[0], 8'($urandom));
      rop(`OP_INC_PFX, i[0], 8'hFF);
      rop(`OP_DEC_PFX, i[0], 8'h80);
      rop(`OP_DEC_PFX, i[0], 8'h00);
      rop(`OP_INCSZ_PFX, i[0], 8'hFF - i[7:0]);
      lit(`OP_ADD_LIT, 8'h55);
      rop(`OP_DECSZ_PFX, i[0], 8'h01 + i[7:0]);
      lit(`OP_ADD_LIT, 8'h55);
      rop(`OP_DECSNZ_PFX, i[0], 8'h05 - {i[5:0], 2'h0});
      lit(`OP_ADD_LIT, 8'h55);
    end
    run_op({`OP_JUMP_PFX, 13'h1ABC}, 8'h00, 1'h0);
    lit(`OP_ADD_LIT, 8'h55);
    run_op(`OP_IRQ_RET, 8'h00, 1'h0);
    lit(`OP_ADD_LIT, 8'h55);
    run_op({`OP_XOR_LIT, 8'h00}, 8'h00, 1'h1);
    run_op(`OP_IRQ_RET, 8'h00, 1'h1);
    lit(`OP_ADD_LIT, 8'h55);
    lit(`OP_RET_LIT, 8'($urandom));
    lit(`OP_ADD_LIT, 8'h55);
    run_op(16'h0000, 8'h00, 1'h0);
    for (i = 0; i < 24; i++) begin
      sel = $urandom % 9;
      if (sel < 7) begin
        rop(pf[sel], 1'($urandom), 8'($urandom));
      end else begin
        lit(sel == 7 ? `OP_ADD_LIT : `OP_XOR_LIT, 8'($urandom));
      end
    end
    for (i = 0; i < 40 && q.size() > 0; i++) @(negedge clk_sys);
    if (q.size() > 0) chk(1'h0, "drain");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
